// *** hdl/io_supply_monitor_control.sv ***
// Module: supply monitor control register and low-supply flag logic with AXI4-Lite slave
// Functional notes
// - Bit 3 reads the live comparator result, 1 while the supply is above the trip point.
// - Bit 3 reads 1 whenever the monitor is switched off.
// - Bit 2 selects the trip point; only 0 (2.79 V) is valid and software keeps it at 0.
// - Bit 1 switches the monitoring circuit on when 1 and off when 0.
// - Bit 0 is set when the above-trip status falls to 0 and stays set until cleared.
// - Writing 1 to bit 0 clears it once the status is back at 1; writing 0 does nothing.
// - A clearing write takes effect at once with no delay once the status is 1.
// - The flag goes out as an interrupt source, reaching the core only if enabled in a mask.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module io_supply_monitor_control
  import supply_watch_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic cmp_above_in,
  output logic monitor_on_out,
  output logic trip_level_select_out,
  output logic low_supply_irq_out,
  input wire logic normal_interrupt_enable_mask_in,
  input wire logic fast_interrupt_enable_mask_in,
  output logic normal_irq_out,
  output logic fast_irq_out,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire axi_addr_s s_axi_aw_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire axi_wdata_s s_axi_w_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire axi_addr_s s_axi_ar_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out
);
  function automatic logic hit(input logic [31:0] a);
    hit = (a[ADDR_LSB_W-1:2] == SUPPLY_MONITOR_CTRL_OFFS[ADDR_LSB_W-1:2]);
  endfunction : hit

  // Comparator is analog and asynchronous: two-stage synchroniser
  logic cmp_meta_r, cmp_sync_r, above_prev_r;
  logic mon_d1_r, mon_d2_r;
  logic mon_on_r, trip_sel_r, flag_r;
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] awaddr_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [15:0] wdata_r;

  // Synchroniser still holds powered-down samples after enable: status held high till flushed
  wire logic mon_live = mon_on_r & mon_d1_r & mon_d2_r;
  wire logic above = cmp_sync_r | ~mon_live;
  wire logic fall_evt = above_prev_r & ~above;
  wire logic [15:0] ctrl_view = {12'h000, above, trip_sel_r, mon_on_r, flag_r};
  wire logic do_wr = aw_got_r & w_got_r & ~bvalid_r;
  wire logic wr_hit = do_wr & hit(awaddr_r);
  wire logic wr_lo = wr_hit & wstrb_r[0];
  wire logic clr_req = wr_lo & wdata_r[BIT_LOW_FLAG];
  wire logic wr_mon_bit = wdata_r[BIT_MON_ON];
  // Set wins over clear; clear needs status back high
  wire logic flag_nxt = fall_evt | ~above | (flag_r & ~(clr_req & above));
  wire logic rd_go = s_axi_arvalid_in & ~rvalid_r;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmp_meta_r <= 1'b1;
      cmp_sync_r <= 1'b1;
      above_prev_r <= CTRL_RESET[BIT_ABOVE];
      mon_d1_r <= CTRL_RESET[BIT_MON_ON];
      mon_d2_r <= CTRL_RESET[BIT_MON_ON];
    end else begin
      cmp_meta_r <= cmp_above_in;
      cmp_sync_r <= cmp_meta_r;
      above_prev_r <= above;
      mon_d1_r <= mon_on_r;
      mon_d2_r <= mon_d1_r;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mon_on_r <= CTRL_RESET[BIT_MON_ON];
      trip_sel_r <= CTRL_RESET[BIT_TRIP_SEL];
      flag_r <= CTRL_RESET[BIT_LOW_FLAG];
    end else begin
      if (wr_lo) begin
        mon_on_r <= wr_mon_bit;
        trip_sel_r <= wdata_r[BIT_TRIP_SEL];
      end
      flag_r <= flag_nxt;
    end
  end

  // Write path: address and data taken in either order
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 16'h0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_aw_in.addr;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_w_in.data[15:0];
        wstrb_r <= s_axi_w_in.strb;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= hit(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= hit(s_axi_ar_in.addr) ? {16'h0000, ctrl_view} : 32'h00000000;
      rresp_r <= hit(s_axi_ar_in.addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready_out = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready_out = ~w_got_r & ~bvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = ~rvalid_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign monitor_on_out = mon_on_r;
  assign trip_level_select_out = trip_sel_r;
  assign low_supply_irq_out = flag_r;
  assign normal_irq_out = flag_r & normal_interrupt_enable_mask_in;
  assign fast_irq_out = flag_r & fast_interrupt_enable_mask_in;

  property p_off_reads_above;
    @(posedge clk_sys_in) disable iff (!nrst_in) !mon_on_r |-> above;
  endproperty
  a_off_reads_above: assert property (p_off_reads_above) else $error("status not 1 when off");
  property p_follow_cmp;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      mon_live |-> ctrl_view[BIT_ABOVE] == $past(cmp_above_in, 2);
  endproperty
  a_follow_cmp: assert property (p_follow_cmp) else $error("status does not follow comparator");
  property p_set_on_low;
    @(posedge clk_sys_in) disable iff (!nrst_in) !above |=> flag_r;
  endproperty
  a_set_on_low: assert property (p_set_on_low) else $error("flag not set on low supply");
  property p_sticky;
    @(posedge clk_sys_in) disable iff (!nrst_in) flag_r && !clr_req |=> flag_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
  property p_clear;
    @(posedge clk_sys_in) disable iff (!nrst_in) flag_r && clr_req && above && !fall_evt |=> !flag_r;
  endproperty
  a_clear: assert property (p_clear) else $error("flag clear failed");
  property p_no_clear_low;
    @(posedge clk_sys_in) disable iff (!nrst_in) clr_req && !above |=> flag_r;
  endproperty
  a_no_clear_low: assert property (p_no_clear_low) else $error("flag cleared while low");
  property p_upper_zero;
    @(posedge clk_sys_in) disable iff (!nrst_in) s_axi_rvalid_out |-> s_axi_rdata_out[31:4] == 28'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
  property p_irq_gate;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      normal_irq_out == (low_supply_irq_out && normal_interrupt_enable_mask_in)
      && fast_irq_out == (low_supply_irq_out && fast_interrupt_enable_mask_in);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");
  property p_enable_write;
    @(posedge clk_sys_in) disable iff (!nrst_in) wr_lo |=> mon_on_r == $past(wr_mon_bit);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not written");
  property p_settle_high;
    @(posedge clk_sys_in) disable iff (!nrst_in) mon_on_r && !mon_live |-> above;
  endproperty
  a_settle_high: assert property (p_settle_high) else $error("status low in settle");
  property p_clear_at_once;
    @(posedge clk_sys_in) disable iff (!nrst_in) clr_req && above
      |=> !low_supply_irq_out && !normal_irq_out && !fast_irq_out;
  endproperty
  a_clear_at_once: assert property (p_clear_at_once) else $error("clear late");
  property p_ignore_bad;
    @(posedge clk_sys_in) disable iff (!nrst_in) do_wr && !hit(awaddr_r)
      |=> $stable(mon_on_r) && $stable(trip_sel_r);
  endproperty
  a_ignore_bad: assert property (p_ignore_bad) else $error("bad write landed");
  property p_rd_zero;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR |-> s_axi_rdata_out == 32'h00000000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("error read not zero");

  c_low_event: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) fall_evt);
  c_clear: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) flag_r && clr_req && above);
  c_clear_low: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) clr_req && !above);
  c_wake: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) $rose(mon_live));
  c_bad_addr: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
endmodule : io_supply_monitor_control

// *** inc/supply_watch_pkg.sv ***
// Package: register map, field positions and bus types for the I/O supply monitor control
package supply_watch_pkg;
  localparam logic [31:0] SUPPLY_MONITOR_CTRL_ADDR = 32'hFFFF0440;
  localparam logic [11:0] SUPPLY_MONITOR_CTRL_OFFS = 12'h440;
  localparam int ADDR_LSB_W = 12;
  localparam int BIT_LOW_FLAG = 0;
  localparam int BIT_MON_ON = 1;
  localparam int BIT_TRIP_SEL = 2;
  localparam int BIT_ABOVE = 3;
  localparam logic [15:0] CTRL_RESET = 16'h0008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] prot;
  } axi_addr_s;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } axi_wdata_s;
endpackage : supply_watch_pkg

// *** verification/io_supply_monitor_control_tb_top.sv ***
// Bench: register, flag and interrupt checks for the supply monitor control
`timescale 1ns/1ps
module io_supply_monitor_control_tb_top import supply_watch_pkg::*;;
  localparam logic [31:0] CA = SUPPLY_MONITOR_CTRL_ADDR;
  logic clk_sys_in = 0, nrst_in = 0, low = 0, nmask = 0, fmask = 0;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  axi_addr_s aw = '0, ar = '0;
  axi_wdata_s w = '0;
  logic cmp, mon, trip, flag, nirq, firq, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rng = 32'h00010ECC;
  logic [33:0] expq[$];
  int fails = 0, samples_checked = 0, cyc = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  supply_comparator_model i_supply_comparator_model (.clk_sys_in(clk_sys_in),
    .supply_low_in(low), .monitor_on_in(mon), .trip_level_select_in(trip), .cmp_above_out(cmp));
  io_supply_monitor_control i_io_supply_monitor_control (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .cmp_above_in(cmp), .monitor_on_out(mon), .trip_level_select_out(trip),
    .low_supply_irq_out(flag), .normal_interrupt_enable_mask_in(nmask),
    .fast_interrupt_enable_mask_in(fmask), .normal_irq_out(nirq), .fast_irq_out(firq),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awrdy), .s_axi_aw_in(aw),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_w_in(w),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arrdy), .s_axi_ar_in(ar),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic k;
    @(posedge clk_sys_in);
    expq.push_back({((a == CA) ? RESP_OKAY : RESP_SLVERR), 32'h00000000});
    aw <= '{a, 3'h0};
    w <= '{d, 4'hF};
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge clk_sys_in);
      k = bvalid;
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!k);
    bready <= 0;
  endtask : wr
  // Expected value is queued here, the watcher below pops it on rvalid
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    logic k;
    @(posedge clk_sys_in);
    expq.push_back(e);
    ar <= '{a, 3'h0};
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge clk_sys_in);
      k = rvalid;
      if (arrdy) arv <= 0;
    end while (!k);
    rready <= 0;
  endtask : rd
  always @(posedge clk_sys_in) begin
    if (rvalid && rready) chk("ctrl read", {rresp, rdata}, expq.pop_front());
    if (bvalid && bready) chk("write resp", {bresp, 32'h00000000}, expq.pop_front());
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd(CA, 34'h8);
    wr(CA, 32'hFFFFFFF2);
    rd(CA, 34'hA);
    chk("monitor on", mon, 34'h1);
    wr(CA + 32'h4, 32'h0);
    rd(CA, 34'hA);
    $display("enable test done");
    low <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    rd(CA, 34'h3);
    chk("low flag", flag, 34'h1);
    wr(CA, 32'h3);
    rd(CA, 34'h3);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      nmask <= rng[0];
      fmask <= rng[1];
      @(posedge clk_sys_in);
      chk("irq", {nirq, firq}, {rng[0], rng[1]});
    end
    nmask <= 1'b1;
    fmask <= 1'b1;
    $display("low supply test done");
    low <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rd(CA, 34'hB);
    wr(CA, 32'h2);
    rd(CA, 34'hB);
    wr(CA, 32'h3);
    rd(CA, 34'hA);
    chk("irq clear", {nirq, firq}, 34'h0);
    $display("clear test done");
    wr(CA, 32'h0);
    low <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    rd(CA, 34'h8);
    chk("trip select", trip, 34'h0);
    chk("flag while off", flag, 34'h0);
    rd(CA + 32'h4, {RESP_SLVERR, 32'h0});
    repeat (3) @(posedge clk_sys_in);
    $display("disable test done");
    end_of_test();
  end
endmodule : io_supply_monitor_control_tb_top

// *** verification/supply_comparator_model.sv ***
// Partner model: analog comparator watching the I/O supply rail
`timescale 1ns/1ps
module supply_comparator_model (
  input wire logic clk_sys_in,
  input wire logic supply_low_in,
  input wire logic monitor_on_in,
  input wire logic trip_level_select_in,
  output logic cmp_above_out
);
  logic idle_r = 1'b0;
  // Powered down, the output means nothing, so it wanders each cycle
  always @(posedge clk_sys_in) idle_r <= ~idle_r;
  // Only the lowest trip point exists; the other setting is not modelled
  assign cmp_above_out = monitor_on_in ? ~supply_low_in : idle_r;
endmodule : supply_comparator_model
